// ===== rtl/rsa_pkg.sv
// Constants shared by the rail strobe assignment block
//
// Function
// - Buck-boost rail step slot sits in bits 7-4 at 0x23, reset 7h.
// - Third buck rail step slot sits in bits 3-0 at 0x23, reset 5h, register 0x75.
// - Slot values 0h-2h and Bh-Fh leave the output outside sequencer control.
// - Slot values 3h through Ah enable the output at step 3 through 10.
// - Register 0x24 resets 0x12; bits 7-6, 3-2 read zero; bits 5-4, 1-0 writable.
// - Linear rail step slot sits in bits 3-0 at 0x25, reset 3h.
// - Bits 7-4 at 0x25 are writable spare, reset 6h, register 0x63.
// - Second general output slot sits in bits 7-4 at 0x26, reset 0h.
// - First general output slot sits in bits 3-0 at 0x26, reset 3h, register 0x03.
// - Each gap between steps waits 2 ms or 5 ms by its own select bit.
// - Power-down delay scale multiplies every gap by 10 during power-down only.
`default_nettype none

package rsa_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_MAP_BB_B3 = 8'h23;
   localparam logic [7:0] OFS_MAP_SPARE = 8'h24;
   localparam logic [7:0] OFS_MAP_LINEAR = 8'h25;
   localparam logic [7:0] OFS_MAP_OUTPUTS = 8'h26;
   localparam logic [7:0] RST_MAP_BB_B3 = 8'h75;
   localparam logic [7:0] RST_MAP_SPARE = 8'h12;
   localparam logic [7:0] RST_MAP_LINEAR = 8'h63;
   localparam logic [7:0] RST_MAP_OUTPUTS = 8'h03;
   localparam logic [7:0] SPARE_WR_MASK = 8'h33;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
   localparam int SLOT_HI_LSB = 4;
   localparam int SLOT_LO_LSB = 0;

   // ----------------------------------------------------------------
   // Steps and outputs
   // ----------------------------------------------------------------
   localparam logic [3:0] SLOT_FIRST_CTRL = 4'h3;
   localparam logic [3:0] SLOT_LAST_CTRL = 4'ha;
   localparam logic [3:0] STEP_FIRST = 4'h1;
   localparam logic [3:0] STEP_LAST = 4'ha;
   localparam int NUM_OUT = 5;
   localparam int OUT_BUCKBOOST = 0;
   localparam int OUT_BUCK_THREE = 1;
   localparam int OUT_LINEAR = 2;
   localparam int OUT_ONE = 3;
   localparam int OUT_TWO = 4;
   localparam int NUM_GAP = 9;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 10;
   localparam int GAP_SHORT_US = 2000;
   localparam int GAP_LONG_US = 5000;
   localparam int GAP_SHORT_CYC = GAP_SHORT_US * CLK_MHZ;
   localparam int GAP_LONG_CYC = GAP_LONG_US * CLK_MHZ;
   localparam int DOWN_SCALE = 10;
   localparam int TMR_W = 20;

   typedef enum logic [1:0] {
      RSA_IDLE = 2'b00,
      RSA_UP = 2'b01,
      RSA_DOWN = 2'b10
   } rsa_state_t;
endpackage

`default_nettype wire

// ===== rtl/rsa_step_decode.sv
// Step slot decoder for one sequenced output
`default_nettype none

module rsa_step_decode (
   input wire logic [3:0] slot_in,
   input wire logic [3:0] step_in,
   output logic ctrl_out,
   output logic hit_out
);
   // Slots outside 3h..Ah are not under sequencer control
   always_comb begin
      ctrl_out = (slot_in >= rsa_pkg::SLOT_FIRST_CTRL) &&
                 (slot_in <= rsa_pkg::SLOT_LAST_CTRL);
      hit_out = ctrl_out && (slot_in == step_in);
   end
endmodule

`default_nettype wire

// ===== rtl/rsa_top.sv
// Step slot registers and strobe sequencer for five outputs
`default_nettype none

module rsa_top #(
   parameter int unsigned GAP_SHORT_CYC = rsa_pkg::GAP_SHORT_CYC,
   parameter int unsigned GAP_LONG_CYC = rsa_pkg::GAP_LONG_CYC
) (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic unlock_in,
   input wire logic seq_up_in,
   input wire logic seq_down_in,
   input wire logic [8:0] gap_select_in,
   input wire logic powerdown_delay_scale_in,
   output logic [7:0] reg_rdata_out,
   output logic seq_busy_out,
   output logic [3:0] step_out,
   output logic step_strobe_out,
   output logic buckboost_rail_en_out,
   output logic buck_three_rail_en_out,
   output logic linear_rail_en_out,
   output logic general_output_one_en_out,
   output logic general_output_two_en_out
);
   localparam int unsigned SCALE = rsa_pkg::DOWN_SCALE;
   localparam logic [19:0] T_SHORT = 20'(GAP_SHORT_CYC - 1);
   localparam logic [19:0] T_LONG = 20'(GAP_LONG_CYC - 1);
   localparam logic [19:0] T_SHORT_X = 20'(GAP_SHORT_CYC * SCALE - 1);
   localparam logic [19:0] T_LONG_X = 20'(GAP_LONG_CYC * SCALE - 1);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   logic [7:0] map_bb_b3_q, map_bb_b3_d;
   logic [7:0] map_spare_q, map_spare_d;
   logic [7:0] map_linear_q, map_linear_d;
   logic [7:0] map_outputs_q, map_outputs_d;
   logic [7:0] rdata_q, rdata_d;
   logic wr_ok;

   always_comb begin
      map_bb_b3_d = map_bb_b3_q;
      map_spare_d = map_spare_q;
      map_linear_d = map_linear_q;
      map_outputs_d = map_outputs_q;
      rdata_d = rdata_q;
      wr_ok = reg_wr_in && unlock_in;
      if (wr_ok) begin
         unique case (reg_addr_in)
            rsa_pkg::OFS_MAP_BB_B3: map_bb_b3_d = reg_wdata_in;
            rsa_pkg::OFS_MAP_SPARE: map_spare_d = reg_wdata_in & rsa_pkg::SPARE_WR_MASK;
            rsa_pkg::OFS_MAP_LINEAR: map_linear_d = reg_wdata_in;
            rsa_pkg::OFS_MAP_OUTPUTS: map_outputs_d = reg_wdata_in;
            default: map_bb_b3_d = map_bb_b3_q;
         endcase
      end
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            rsa_pkg::OFS_MAP_BB_B3: rdata_d = map_bb_b3_q;
            rsa_pkg::OFS_MAP_SPARE: rdata_d = map_spare_q;
            rsa_pkg::OFS_MAP_LINEAR: rdata_d = map_linear_q;
            rsa_pkg::OFS_MAP_OUTPUTS: rdata_d = map_outputs_q;
            default: rdata_d = rsa_pkg::RDATA_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         map_bb_b3_q <= rsa_pkg::RST_MAP_BB_B3;
         map_spare_q <= rsa_pkg::RST_MAP_SPARE;
         map_linear_q <= rsa_pkg::RST_MAP_LINEAR;
         map_outputs_q <= rsa_pkg::RST_MAP_OUTPUTS;
         rdata_q <= 8'h00;
      end else begin
         map_bb_b3_q <= map_bb_b3_d;
         map_spare_q <= map_spare_d;
         map_linear_q <= map_linear_d;
         map_outputs_q <= map_outputs_d;
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // Slot decode
   // ----------------------------------------------------------------
   logic [3:0] slot [rsa_pkg::NUM_OUT];
   logic [rsa_pkg::NUM_OUT-1:0] ctrl;
   logic [rsa_pkg::NUM_OUT-1:0] hit;
   logic [3:0] step_q, step_d;

   always_comb begin
      slot[rsa_pkg::OUT_BUCKBOOST] = map_bb_b3_q[rsa_pkg::SLOT_HI_LSB +: 4];
      slot[rsa_pkg::OUT_BUCK_THREE] = map_bb_b3_q[rsa_pkg::SLOT_LO_LSB +: 4];
      slot[rsa_pkg::OUT_LINEAR] = map_linear_q[rsa_pkg::SLOT_LO_LSB +: 4];
      slot[rsa_pkg::OUT_ONE] = map_outputs_q[rsa_pkg::SLOT_LO_LSB +: 4];
      slot[rsa_pkg::OUT_TWO] = map_outputs_q[rsa_pkg::SLOT_HI_LSB +: 4];
   end

   for (genvar i = 0; i < rsa_pkg::NUM_OUT; i++) begin : g_dec
      rsa_step_decode u_dec (
         .slot_in(slot[i]),
         .step_in(step_q),
         .ctrl_out(ctrl[i]),
         .hit_out(hit[i])
      );
   end

   // ----------------------------------------------------------------
   // Strobe sequencer
   // ----------------------------------------------------------------
   rsa_pkg::rsa_state_t state_q, state_d;
   logic [19:0] tmr_q, tmr_d;
   logic [rsa_pkg::NUM_OUT-1:0] en_q, en_d;
   logic strobe_q, strobe_d;
   logic fire;
   logic gap_long;
   logic [3:0] gap_idx;
   logic busy_q, busy_d;

   always_comb begin
      state_d = state_q;
      tmr_d = tmr_q;
      step_d = step_q;
      en_d = en_q & ctrl;
      fire = (state_q != rsa_pkg::RSA_IDLE) && (tmr_q == 20'h00000);
      strobe_d = fire;
      gap_idx = (state_q == rsa_pkg::RSA_DOWN) ? step_q - 4'h2 : step_q - 4'h1;
      // Steps without a following gap index past the select bits
      gap_long = (gap_idx < 4'(rsa_pkg::NUM_GAP)) ? gap_select_in[gap_idx] : 1'b0;
      unique case (state_q)
         rsa_pkg::RSA_IDLE: begin
            if (seq_up_in) begin
               state_d = rsa_pkg::RSA_UP;
               step_d = rsa_pkg::STEP_FIRST;
               tmr_d = 20'h00000;
            end else if (seq_down_in) begin
               state_d = rsa_pkg::RSA_DOWN;
               step_d = rsa_pkg::STEP_LAST;
               tmr_d = 20'h00000;
            end
         end
         rsa_pkg::RSA_UP: begin
            if (fire) begin
               en_d = (en_q | hit) & ctrl;
               if (step_q == rsa_pkg::STEP_LAST) begin
                  state_d = rsa_pkg::RSA_IDLE;
               end else begin
                  step_d = step_q + 4'h1;
                  tmr_d = gap_long ? T_LONG : T_SHORT;
               end
            end else begin
               tmr_d = tmr_q - 20'h00001;
            end
         end
         rsa_pkg::RSA_DOWN: begin
            if (fire) begin
               en_d = en_q & ~hit & ctrl;
               if (step_q == rsa_pkg::STEP_FIRST) begin
                  state_d = rsa_pkg::RSA_IDLE;
               end else begin
                  step_d = step_q - 4'h1;
                  if (powerdown_delay_scale_in) begin
                     tmr_d = gap_long ? T_LONG_X : T_SHORT_X;
                  end else begin
                     tmr_d = gap_long ? T_LONG : T_SHORT;
                  end
               end
            end else begin
               tmr_d = tmr_q - 20'h00001;
            end
         end
         default: state_d = rsa_pkg::RSA_IDLE;
      endcase
      busy_d = (state_d != rsa_pkg::RSA_IDLE);
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= rsa_pkg::RSA_IDLE;
         tmr_q <= 20'h00000;
         step_q <= rsa_pkg::STEP_FIRST;
         en_q <= '0;
         strobe_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         tmr_q <= tmr_d;
         step_q <= step_d;
         en_q <= en_d;
         strobe_q <= strobe_d;
         busy_q <= busy_d;
      end
   end

   always_comb begin
      reg_rdata_out = rdata_q;
      seq_busy_out = busy_q;
      step_out = step_q;
      step_strobe_out = strobe_q;
      buckboost_rail_en_out = en_q[rsa_pkg::OUT_BUCKBOOST];
      buck_three_rail_en_out = en_q[rsa_pkg::OUT_BUCK_THREE];
      linear_rail_en_out = en_q[rsa_pkg::OUT_LINEAR];
      general_output_one_en_out = en_q[rsa_pkg::OUT_ONE];
      general_output_two_en_out = en_q[rsa_pkg::OUT_TWO];
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   locked_write_a: assert property (reg_wr_in && !unlock_in |=>
      $stable(map_bb_b3_q) && $stable(map_spare_q) && $stable(map_linear_q)
      && $stable(map_outputs_q)) else $error("locked write changed a register");
   spare_ro_a: assert property ((map_spare_q & ~rsa_pkg::SPARE_WR_MASK) == 8'h00)
      else $error("read-only spare bits not zero");
   read_bbb3_a: assert property (reg_rd_in && reg_addr_in == 8'h23 && !reg_wr_in
      |=> reg_rdata_out == $past(map_bb_b3_q)) else $error("bad readback at 0x23");
   write_outputs_a: assert property (wr_ok && reg_addr_in == 8'h26
      |=> map_outputs_q == $past(reg_wdata_in)) else $error("0x26 write lost");
   write_linear_a: assert property (wr_ok && reg_addr_in == 8'h25
      |=> map_linear_q == $past(reg_wdata_in)) else $error("0x25 write lost");
   uncontrolled_off_a: assert property (!ctrl[rsa_pkg::OUT_ONE] && !wr_ok
      |=> !general_output_one_en_out) else $error("uncontrolled output enabled");
   step_enable_a: assert property (state_q == rsa_pkg::RSA_UP && fire
      && hit[rsa_pkg::OUT_LINEAR] && !wr_ok |=> linear_rail_en_out)
      else $error("output not enabled at its step");
   gap_up_a: assert property (state_q == rsa_pkg::RSA_UP && fire && step_q != 4'ha
      |=> tmr_q == ($past(gap_long) ? T_LONG : T_SHORT)) else $error("bad up gap");
   gap_down_a: assert property (state_q == rsa_pkg::RSA_DOWN && fire && step_q != 4'h1
      |=> tmr_q == ($past(powerdown_delay_scale_in) ? ($past(gap_long) ? T_LONG_X : T_SHORT_X)
      : ($past(gap_long) ? T_LONG : T_SHORT))) else $error("bad down gap");
endmodule

`default_nettype wire

// ===== tb/rsa_top_tb_top.sv
// Self-checking bench for the rail strobe assignment block
`default_nettype none

module rsa_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int SH = 4;
   localparam int LG = 7;

   logic clk_in = 1'b0;
   logic resetn_in, reg_wr_in, reg_rd_in, unlock_in, seq_up_in, seq_down_in, scale;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
   logic [8:0] sel;
   logic seq_busy_out, step_strobe_out;
   logic [3:0] step_out;
   logic [4:0] en_vec;
   logic [31:0] lfsr_q = 32'haee8;
   logic [7:0] exp_reg [4];
   logic [3:0] sl [5];
   int bad_count = 0;
   int n_tests = 0;

   rsa_top #(.GAP_SHORT_CYC(SH), .GAP_LONG_CYC(LG)) i_rsa_top (
      .clk_in(clk_in), .resetn_in(resetn_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .unlock_in(unlock_in),
      .seq_up_in(seq_up_in), .seq_down_in(seq_down_in), .gap_select_in(sel),
      .powerdown_delay_scale_in(scale), .reg_rdata_out(reg_rdata_out),
      .seq_busy_out(seq_busy_out), .step_out(step_out), .step_strobe_out(step_strobe_out),
      .buckboost_rail_en_out(en_vec[0]), .buck_three_rail_en_out(en_vec[1]),
      .linear_rail_en_out(en_vec[2]), .general_output_one_en_out(en_vec[3]),
      .general_output_two_en_out(en_vec[4]));

   always #50 clk_in = ~clk_in;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] rnd();
      lfsr_q = {lfsr_q[30:0], ^(lfsr_q & 32'h80200003)};
      return lfsr_q[7:0];
   endfunction

   function automatic logic en_exp(logic [3:0] s, logic [3:0] k, logic dn);
      return (s >= 4'h3) && (s <= 4'ha) && (dn ? (s < k) : (s <= k));
   endfunction

   function automatic logic [7:0] gap_exp(logic [3:0] kp, logic dn);
      int g;
      g = (dn ? sel[kp - 4'h2] : sel[kp - 4'h1]) ? LG : SH;
      if (dn && scale) g = g * 10;
      return 8'(g);
   endfunction

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wrap_up();
      if (bad_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
      @(posedge clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      unlock_in <= u;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      unlock_in <= 1'b0;
      if (u && a >= 8'h23 && a <= 8'h26) begin
         exp_reg[a - 8'h23] = (a == 8'h24) ? (d & 8'h33) : d;
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_in);
      check("rdata", reg_rdata_out, exp);
   endtask

   // One run; a start pulse mid-run must be ignored while busy
   task automatic run_seq(input logic dn);
      int cyc, last, j;
      logic [3:0] k;
      @(posedge clk_in);
      if (dn) seq_down_in <= 1'b1;
      else seq_up_in <= 1'b1;
      @(posedge clk_in);
      seq_up_in <= 1'b0;
      seq_down_in <= 1'b0;
      j = 0;
      last = 0;
      for (cyc = 1; cyc < 2000 && j < 10; cyc++) begin
         @(posedge clk_in);
         seq_up_in <= (cyc == 5);
         #1;
         if (step_strobe_out === 1'b1) begin
            j++;
            k = dn ? 4'(11 - j) : 4'(j);
            if (j > 1) check("gap", 8'(cyc - last), gap_exp(dn ? k + 4'h1 : k - 4'h1, dn));
            check("step", {4'h0, step_out},
               {4'h0, (k == (dn ? 4'h1 : 4'ha)) ? k : (dn ? k - 4'h1 : k + 4'h1)});
            check("busy", {7'h0, seq_busy_out}, {7'h0, k != (dn ? 4'h1 : 4'ha)});
            last = cyc;
            for (int i = 0; i < 5; i++) begin
               check("enable", {7'h0, en_vec[i]}, {7'h0, en_exp(sl[i], k, dn)});
            end
         end
      end
      if (j < 10) begin
         bad_count++;
      end
      repeat (3) @(posedge clk_in);
      #1;
      check("busy", {7'h0, seq_busy_out}, 8'h00);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      resetn_in = 1'b0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      unlock_in = 1'b0;
      seq_up_in = 1'b0;
      seq_down_in = 1'b0;
      scale = 1'b0;
      sel = 9'h000;
      reg_addr_in = 8'h00;
      reg_wdata_in = 8'h00;
      exp_reg = '{8'h75, 8'h12, 8'h63, 8'h03};
      repeat (6) @(posedge clk_in);
      resetn_in <= 1'b1;
      check("enables", {3'h0, en_vec}, 8'h00);
      for (int i = 0; i < 4; i++) rd(8'(8'h23 + i), exp_reg[i]);
      rd(8'h30, 8'h00);
      wr(8'h23, 8'h00, 1'b0);
      wr(8'h24, 8'hff, 1'b1);
      wr(8'h27, 8'hff, 1'b1);
      rd(8'h23, exp_reg[0]);
      rd(8'h24, exp_reg[1]);
      rd(8'h27, 8'h00);
      for (int r = 0; r < 4; r++) begin
         if (r == 0) sl = '{4'h3, 4'ha, 4'h2, 4'hb, 4'h0};
         else if (r == 1) sl = '{4'h9, 4'h1, 4'h4, 4'hf, 4'h5};
         else for (int i = 0; i < 5; i++) sl[i] = 4'(rnd() % 8'd12);
         sel <= 9'({rnd(), rnd()} % 16'h01ff);
         scale <= r[0];
         wr(8'h23, {sl[0], sl[1]}, 1'b1);
         wr(8'h24, rnd(), 1'b1);
         wr(8'h25, {4'(rnd()), sl[2]}, 1'b1);
         wr(8'h26, {sl[4], sl[3]}, 1'b1);
         for (int i = 0; i < 4; i++) rd(8'(8'h23 + i), exp_reg[i]);
         run_seq(1'b0);
         run_seq(1'b1);
      end
      // Reset in the middle of a power-up run restores every register
      @(posedge clk_in);
      seq_up_in <= 1'b1;
      @(posedge clk_in);
      seq_up_in <= 1'b0;
      repeat (40) @(posedge clk_in);
      resetn_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      exp_reg = '{8'h75, 8'h12, 8'h63, 8'h03};
      @(negedge clk_in);
      check("enables", {3'h0, en_vec}, 8'h00);
      check("busy", {7'h0, seq_busy_out}, 8'h00);
      check("step", {4'h0, step_out}, 8'h01);
      for (int i = 0; i < 4; i++) rd(8'(8'h23 + i), exp_reg[i]);
      wrap_up();
   end
endmodule

`default_nettype wire
